/* bench/chain_feeder.sv */
`timescale 1ns/1ps
`default_nettype none
module chain_feeder (
  // link clock and reset
  input  wire logic       lclk,
  input  wire logic       rst_n,
  // request count from the bench, handshake with the router
  input  wire logic [7:0] req_cnt,
  input  wire logic       in_ready,
  output logic            in_valid,
  output logic [7:0]      sent_cnt
);
  // one descriptor in flight: valid rises only while ready is high, drops on the take
  always_ff @(posedge lclk or negedge rst_n) begin
    if (!rst_n) begin
      in_valid <= 1'h0;
      sent_cnt <= 8'h00;
    end else if (in_valid && in_ready) begin
      in_valid <= 1'h0;
      sent_cnt <= sent_cnt + 8'h01;
    end else if (in_ready && req_cnt != sent_cnt) begin
      in_valid <= 1'h1;
    end
  end
endmodule
`default_nettype wire

/* bench/switch_partition_router_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module switch_partition_router_tb;
  import swr_pkg::*;
  logic clk = 0, lclk = 0, rst_n = 0, ce = 1, in_valid, in_ready, in_compat = 0, in_bridge = 0;
  logic [7:0] req_cnt = 0, sent_cnt, in_bus = 0;
  logic [1:0] in_port = 0, in_dec_port = 0, eg_port, eg_in_port;
  kind_t in_kind = K_POSTED, eg_kind;
  rsp_t in_rsp = R_NORMAL, eg_rsp;
  act_t eg_act;
  logic [4:0] in_src_tag = 0, in_unit = 0, in_dev = 0, devnum_wdata = 0, eg_src_tag, eg_unit;
  logic [3:0] in_seq = 0, eg_seq, is_primary = 4'h3, mabort_mode = 0, up_cfg_en = 4'hF;
  logic [3:0] tunnel_role_in = 4'hF, dec_en_set = 0, devnum_wr = 0, dec_en, tunnel_role;
  logic [15:0] part_mask = 16'hFFFF;
  logic [7:0] dflt_port = 8'h0E;
  logic [19:0] port_unit = {5'h04, 5'h03, 5'h02, 5'h01};
  logic [31:0] sec_bus = 32'h00050000, sub_bus = 32'h00070000, pri_bus = 0;
  logic eg_valid, eg_compat;
  logic [3:0] chain_end_fault, inbound_chain_end_fault, unmatched_reply_fault;
  logic [3:0] sts_rx_mabort, sec_rx_mabort, sts_rx_tabort, sec_rx_tabort;
  logic [3:0] sts_sig_tabort, sec_sig_tabort;
  int failures = 0, tests_run = 0, cyc = 0;
  switch_partition_router #(.NP(4), .NT(8), .PART_EN(1'h1)) uut (.*);
  chain_feeder feeder (.*);
  // two unrelated clocks
  always #2 clk = ~clk;
  always #3 lclk = ~lclk;
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask
  // set the main descriptor fields on a falling edge
  task automatic pk(input logic [1:0] p, input kind_t k, input logic c, input logic [1:0] d);
    @(negedge clk);
    in_port = p;
    in_kind = k;
    in_compat = c;
    in_dec_port = d;
  endtask
  // hand one descriptor over, then wait a bounded time for its decision
  task automatic go;
    int i;
    logic ev;
    ev = 0;
    req_cnt = req_cnt + 8'h01;
    for (i = 0; i < 200 && !ev; i++) begin
      @(posedge clk);
      #1 ev = eg_valid;
    end
    chk("eg_valid", 1, ev);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_dflt;
    chk("dec_en", 0, dec_en);
    chk("tunnel_role", 4'h3, tunnel_role);
    // enable low must swallow a set pulse
    @(negedge clk) ce = 0; dec_en_set = 4'h2;
    @(negedge clk) ce = 1; dec_en_set = 4'h0;
    chk("frozen", 0, dec_en);
    pk(0, K_POSTED, 0, 3); go;
    chk("dflt port", 2, eg_port);
    @(negedge clk) dec_en_set = 4'h1;
    @(negedge clk) dec_en_set = 4'h0;
    pk(0, K_POSTED, 1, 3); go;
    chk("compat port", 2, eg_port);
    pk(0, K_POSTED, 0, 3); go;
    chk("decoded port", 3, eg_port);
    pk(2, K_POSTED, 1, 3); go;
    chk("peer port", 3, eg_port);
    chk("compat cleared", 0, eg_compat);
  endtask
  task automatic t_ff;
    pk(0, K_FLUSH, 0, 2); go;
    chk("ds flush", A_MAREPLY, eg_act);
    pk(0, K_FENCE, 0, 2); go;
    chk("ds fence", A_DROP, eg_act);
    chk("fence fault", 4'h1, chain_end_fault);
    pk(2, K_FENCE, 0, 3); go;
    chk("us fence", {eg_port, eg_act}, {2'h0, A_FWD});
  endtask
  // request down, responses back up through the table
  task automatic t_resp;
    pk(0, K_NONPOSTED, 0, 2); in_src_tag = 5'h09; in_seq = 4'h3; go;
    chk("np fwd", {eg_port, eg_src_tag}, {2'h2, 5'h00});
    chk("np unit", 5'h03, eg_unit);
    pk(2, K_RESP, 0, 0); in_src_tag = 0; in_rsp = R_MABORT; go;
    chk("rsp route", {eg_port, eg_src_tag, eg_seq}, {2'h0, 5'h09, 4'h3});
    chk("mabort normal", R_NORMAL, eg_rsp);
    chk("rx mabort", 4'h4, sec_rx_mabort);
    pk(0, K_NONPOSTED, 0, 2); in_src_tag = 5'h07; mabort_mode = 4'h4; go;
    chk("entry freed", 0, eg_src_tag);
    pk(2, K_RESP, 0, 0); in_src_tag = 0; in_rsp = R_MABORT; go;
    chk("escalate", R_TABORT, eg_rsp);
    chk("esc flags", {sec_rx_mabort, sts_sig_tabort, sec_rx_tabort}, 12'h451);
    chk("sts rx mabort", 0, sts_rx_mabort);
    pk(0, K_NONPOSTED, 0, 2); in_src_tag = 5'h06; go;
    pk(2, K_RESP, 0, 0); in_src_tag = 0; in_rsp = R_TABORT; go;
    chk("tabort", {eg_rsp, sec_rx_tabort, sts_sig_tabort}, {R_TABORT, 8'h55});
    pk(2, K_RESP, 0, 0); in_bridge = 1; go;
    chk("bridge drop", {eg_act, inbound_chain_end_fault}, {A_DROP, 4'h4});
    pk(2, K_RESP, 0, 0); in_bridge = 0; in_src_tag = 5'h05; go;
    chk("unmatched", {eg_act, unmatched_reply_fault}, {A_DROP, 4'h4});
    pk(0, K_RESP, 0, 0); in_rsp = R_NORMAL; go;
    chk("ds rsp drop", {eg_act, chain_end_fault}, {A_DROP, 4'h1});
    // peer request, abort coming back toward a secondary egress
    pk(3, K_NONPOSTED, 0, 2); go;
    chk("peer np", {eg_port, eg_src_tag}, {2'h2, 5'h00});
    pk(2, K_RESP, 0, 0); in_src_tag = 0; in_rsp = R_TABORT; go;
    chk("peer abort", {eg_port, sts_rx_tabort, sec_sig_tabort, sec_rx_tabort}, 14'h3884);
    chk("peer sig", 4'h4, sts_sig_tabort);
  endtask
  task automatic t_cfg;
    pk(2, K_CFG0, 0, 0); in_dev = 0; go;
    chk("cfg0 idx0", A_CFGHIT, eg_act);
    @(negedge clk) devnum_wr = 4'h4; devnum_wdata = 5'h05;
    @(negedge clk) devnum_wr = 4'h0;
    pk(2, K_CFG0, 0, 0); in_dev = 5'h05; go;
    chk("cfg0 idx5", A_CFGHIT, eg_act);
    pk(0, K_CFG0, 0, 0); go;
    chk("cfg0 pri", A_CFGHIT, eg_act);
    pk(0, K_CFG1, 0, 0); in_bus = 0; in_dev = 5'h03; go;
    chk("vib hit", A_CFGHIT, eg_act);
    pk(0, K_CFG1, 0, 0); in_bus = 8'h06; go;
    chk("cfg1 range", {eg_act, eg_port}, {A_FWD, 2'h2});
    pk(2, K_CFG1, 0, 0); in_bus = 8'h20; up_cfg_en = 0; go;
    chk("up cfg off", 0, eg_act == A_FWD);
    pk(2, K_CFG1, 0, 0); up_cfg_en = 4'hF; go;
    chk("up cfg on", {eg_act, eg_port}, {A_FWD, 2'h0});
  endtask
  task automatic t_part;
    pk(0, K_POSTED, 0, 3); part_mask = 16'hEFFF; go;
    chk("one sided", A_DROP, eg_act);
    pk(2, K_POSTED, 0, 0); part_mask = 16'hFEFF; go;
    chk("us mask", {eg_act, eg_port}, {A_FWD, 2'h0});
  endtask
  // fill the request table; the next nonposted request must wait
  task automatic t_full;
    int ev = 0;
    for (int i = 0; i < 6; i++) begin
      pk(0, K_NONPOSTED, 0, 2); part_mask = 16'hFFFF; go;
    end
    chk("last tag", 5'h07, eg_src_tag);
    pk(0, K_NONPOSTED, 0, 2); req_cnt = req_cnt + 8'h01;
    repeat (60) begin
      @(posedge clk);
      #1 ev = ev + eg_valid;
    end
    chk("stall", 0, ev);
    chk("stall ready", 0, in_ready);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // a hang counts as a mismatch and ends the run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      summarize;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk) rst_n = 1;
    repeat (6) @(negedge clk);
    t_dflt;
    t_ff;
    t_resp;
    t_cfg;
    t_part;
    t_full;
    summarize;
  end
endmodule
`default_nettype wire

/* rtl/switch_partition_router.sv */
`timescale 1ns/1ps
`default_nettype none
module switch_partition_router #(
  parameter int NP      = 4,
  parameter int NT      = 8,
  parameter bit PART_EN = 1'h1
) (
  // core clock, reset, enable
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          ce,
  // ingress descriptor on the link clock
  input  wire logic                          lclk,
  input  wire logic                          in_valid,
  output logic                               in_ready,
  input  wire logic [$clog2(NP)-1:0]         in_port,
  input  wire swr_pkg::kind_t                in_kind,
  input  wire logic                          in_compat,
  input  wire logic                          in_bridge,
  input  wire logic [swr_pkg::TAG_W-1:0]     in_src_tag,
  input  wire logic [swr_pkg::SEQ_W-1:0]     in_seq,
  input  wire logic [swr_pkg::UNIT_W-1:0]    in_unit,
  input  wire logic [swr_pkg::BUS_W-1:0]     in_bus,
  input  wire logic [swr_pkg::DEV_W-1:0]     in_dev,
  input  wire swr_pkg::rsp_t                 in_rsp,
  input  wire logic [$clog2(NP)-1:0]         in_dec_port,
  // per-port configuration
  input  wire logic [NP-1:0]                 is_primary,
  input  wire logic [NP*NP-1:0]              part_mask,
  input  wire logic [NP*$clog2(NP)-1:0]      dflt_port,
  input  wire logic [NP-1:0]                 mabort_mode,
  input  wire logic [NP-1:0]                 up_cfg_en,
  input  wire logic [NP*swr_pkg::UNIT_W-1:0] port_unit,
  input  wire logic [NP*swr_pkg::BUS_W-1:0]  sec_bus,
  input  wire logic [NP*swr_pkg::BUS_W-1:0]  sub_bus,
  input  wire logic [NP*swr_pkg::BUS_W-1:0]  pri_bus,
  input  wire logic [NP-1:0]                 tunnel_role_in,
  input  wire logic [NP-1:0]                 dec_en_set,
  input  wire logic [NP-1:0]                 devnum_wr,
  input  wire logic [swr_pkg::DEV_W-1:0]     devnum_wdata,
  // configuration state shown back
  output logic [NP-1:0]                      dec_en,
  output logic [NP-1:0]                      tunnel_role,
  // egress decision
  output logic                               eg_valid,
  output logic [$clog2(NP)-1:0]              eg_port,
  output logic [$clog2(NP)-1:0]              eg_in_port,
  output swr_pkg::act_t                      eg_act,
  output swr_pkg::kind_t                     eg_kind,
  output logic                               eg_compat,
  output logic [swr_pkg::TAG_W-1:0]          eg_src_tag,
  output logic [swr_pkg::SEQ_W-1:0]          eg_seq,
  output logic [swr_pkg::UNIT_W-1:0]         eg_unit,
  output swr_pkg::rsp_t                      eg_rsp,
  // per-port status pulses
  output logic [NP-1:0]                      chain_end_fault,
  output logic [NP-1:0]                      inbound_chain_end_fault,
  output logic [NP-1:0]                      unmatched_reply_fault,
  output logic [NP-1:0]                      sts_rx_mabort,
  output logic [NP-1:0]                      sec_rx_mabort,
  output logic [NP-1:0]                      sts_rx_tabort,
  output logic [NP-1:0]                      sec_rx_tabort,
  output logic [NP-1:0]                      sts_sig_tabort,
  output logic [NP-1:0]                      sec_sig_tabort
);
  import swr_pkg::*;
  localparam int PW = $clog2(NP);
  localparam int EW = $clog2(NT);

  typedef struct packed {
    logic [PW-1:0]     port;
    kind_t             kind;
    logic              compat;
    logic              bridge;
    logic [TAG_W-1:0]  tag;
    logic [SEQ_W-1:0]  seq;
    logic [UNIT_W-1:0] unit;
    logic [BUS_W-1:0]  bus;
    logic [DEV_W-1:0]  dev;
    rsp_t              rsp;
    logic [PW-1:0]     dport;
  } desc_t;

  typedef struct packed {
    desc_t d;
    logic  req;
    logic  ack_s1;
    logic  ack_s2;
  } lnk_t;

  typedef struct packed {
    logic                          req_s1;
    logic                          req_s2;
    logic                          seen;
    logic [NP-1:0]                 dec_en;
    logic [NP-1:0][DEV_W-1:0]      devnum;
    logic [NT-1:0]                 tv;
    logic [NT-1:0][TAG_W-1:0]      ttag;
    logic [NT-1:0][SEQ_W-1:0]      tseq;
    logic [NT-1:0][UNIT_W-1:0]     tunit;
    logic [NT-1:0][PW-1:0]         tport;
    logic                          eg_valid;
    logic [PW-1:0]                 eg_port;
    logic [PW-1:0]                 eg_in;
    act_t                          eg_act;
    kind_t                         eg_kind;
    logic                          eg_compat;
    logic [TAG_W-1:0]              eg_tag;
    logic [SEQ_W-1:0]              eg_seq;
    logic [UNIT_W-1:0]             eg_unit;
    rsp_t                          eg_rsp;
    logic [NP-1:0]                 f_ce;
    logic [NP-1:0]                 f_ice;
    logic [NP-1:0]                 f_unm;
    logic [NP-1:0]                 s_rma;
    logic [NP-1:0]                 x_rma;
    logic [NP-1:0]                 s_rta;
    logic [NP-1:0]                 x_rta;
    logic [NP-1:0]                 s_sta;
    logic [NP-1:0]                 x_sta;
  } core_t;

  ////////////////////////////////////////////////////////////////////////////
  // field access and partition checks

  function automatic logic same_part(input logic [PW-1:0] a, input logic [PW-1:0] b);
    // no partition support means one common partition
    return !PART_EN || (part_mask[a*NP+b] && part_mask[b*NP+a]);
  endfunction

  function automatic logic reach(input logic [PW-1:0] a, input logic [PW-1:0] e);
    // secondary toward primary ignores its own primary bits
    if (!is_primary[a] && is_primary[e]) return !PART_EN || part_mask[e*NP+a];
    return same_part(a, e);
  endfunction

  function automatic logic [BUS_W-1:0] bfld(input logic [NP*BUS_W-1:0] v, input int p);
    return v[p*BUS_W +: BUS_W];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset synchronisers, one per domain

  logic [1:0] rsc_q;
  logic [1:0] rsl_q;
  logic       rst_c;
  logic       rst_l;

  // release synchronised to each clock, assertion stays asynchronous
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rsc_q <= 2'h0;
    else rsc_q <= {rsc_q[0], 1'h1};
  end

  always_ff @(posedge lclk or negedge rst_n) begin
    if (!rst_n) rsl_q <= 2'h0;
    else rsl_q <= {rsl_q[0], 1'h1};
  end

  assign rst_c = rsc_q[1];
  assign rst_l = rsl_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // link side: hold one descriptor and toggle a request

  lnk_t l;
  lnk_t ln;
  core_t c;
  core_t n;

  // ready only once the core has acknowledged the last toggle; this is
  // also how a full request table stalls the source
  assign in_ready = (l.req == l.ack_s2);

  always_comb begin
    ln = l;
    ln.ack_s1 = c.seen;
    ln.ack_s2 = l.ack_s1;
    if (in_valid && in_ready) begin
      ln.d = {in_port, in_kind, in_compat, in_bridge, in_src_tag, in_seq,
              in_unit, in_bus, in_dev, in_rsp, in_dec_port};
      ln.req = ~l.req;
    end
  end

  always_ff @(posedge lclk or negedge rst_l) begin
    if (!rst_l) l <= '0;
    else l <= ln;
  end

  ////////////////////////////////////////////////////////////////////////////
  // core side: route the held descriptor

  desc_t         d;
  logic          pend;
  logic          full;
  logic [EW-1:0] fi;
  logic          alloc;

  // the held descriptor is stable while a request toggle is outstanding
  assign d = l.d;
  assign pend = (c.req_s2 != c.seen);

  always_comb begin
    logic [PW-1:0]    ip;
    logic [PW-1:0]    dp;
    logic [PW-1:0]    eg;
    logic [PW-1:0]    t;
    logic [EW-1:0]    ix;
    logic             ipri;
    logic             hit;
    logic             cpt;
    act_t             act;
    rsp_t             rsp;
    logic [TAG_W-1:0] tg;
    logic [SEQ_W-1:0] sq;
    logic [UNIT_W-1:0] un;
    n = c;
    ip = d.port;
    dp = dflt_port[ip*PW +: PW];
    ipri = is_primary[ip];
    ix = d.tag[EW-1:0];
    eg = ip;
    t = '0;
    hit = 1'h0;
    cpt = d.compat;
    act = A_DROP;
    rsp = d.rsp;
    tg = d.tag;
    sq = d.seq;
    un = d.unit;
    alloc = 1'h0;
    full = &c.tv;
    fi = '0;
    for (int i = NT - 1; i >= 0; i--) begin
      if (!c.tv[i]) fi = EW'(i);
    end
    n.req_s1 = l.req;
    n.req_s2 = c.req_s1;
    n.eg_valid = 1'h0;
    {n.f_ce, n.f_ice, n.f_unm, n.s_rma, n.x_rma} = '0;
    {n.s_rta, n.x_rta, n.s_sta, n.x_sta} = '0;
    // software sets decode enable; it only clears at reset
    n.dec_en = c.dec_en | dec_en_set;
    for (int p = 0; p < NP; p++) begin
      if (devnum_wr[p]) n.devnum[p] = devnum_wdata;
    end
    if (pend) begin
      case (d.kind)
        K_RESP: begin
          // downstream response must carry bridge flag and port node
          if (ipri && (!d.bridge || d.unit != port_unit[ip*UNIT_W +: UNIT_W])) begin
            n.f_ce[ip] = 1'h1;
          end else if (!ipri && d.bridge) begin
            n.f_ice[ip] = 1'h1;
          end else if ((d.tag >> EW) == '0 && c.tv[ix]) begin
            // restore the original fields and free the entry
            eg = c.tport[ix];
            tg = c.ttag[ix];
            sq = c.tseq[ix];
            un = c.tunit[ix];
            act = A_FWD;
            // entry released as its response leaves
            n.tv[ix] = 1'h0;
            if (!ipri && eg != ip && d.rsp != R_NORMAL) begin
              // master abort escalates or becomes a plain reply
              if (d.rsp == R_MABORT) begin
                n.x_rma[ip] = 1'h1;
                hit = mabort_mode[ip];
                rsp = hit ? R_TABORT : R_NORMAL;
              end else begin
                hit = 1'h1;
                n.x_rta[ip] = 1'h1;
              end
              // target abort flags on both ports, register by port type
              if (hit) begin
                n.s_sta[ip] = 1'h1;
                if (is_primary[eg]) begin
                  n.x_rta[eg] = 1'h1;
                  n.s_sta[eg] = 1'h1;
                end else begin
                  n.s_rta[eg] = 1'h1;
                  n.x_sta[eg] = 1'h1;
                end
              end
            end
          end else begin
            n.f_unm[ip] = 1'h1;
          end
        end
        K_CFG0: begin
          // own header; secondary answers at its device index
          if (ipri || d.dev == c.devnum[ip]) act = A_CFGHIT;
          else act = A_MAREPLY;
        end
        K_CFG1: begin
          act = A_MAREPLY;
          // internal bus number chosen by direction
          if (d.bus == (ipri ? bfld(sec_bus, ip) : bfld(pri_bus, ip))) begin
            t = d.dev[PW-1:0];
            // secondary header at device equal to its port number
            if ((d.dev >> PW) == '0 && !is_primary[t] && same_part(ip, t)) begin
              act = A_CFGHIT;
              eg = t;
            end
          end else if (ipri) begin
            // downstream by secondary-to-subordinate range
            // mutual membership, so the forward also stays inside the partition
            for (int s = NP - 1; s >= 0; s--) begin
              if (!is_primary[s] && same_part(ip, PW'(s)) &&
                  d.bus >= bfld(sec_bus, s) && d.bus <= bfld(sub_bus, s)) begin
                act = A_FWD;
                eg = PW'(s);
              end
            end
          // upstream only with the upward permission bit
          end else if (up_cfg_en[ip] && reach(ip, dp)) begin
            act = A_FWD;
            eg = dp;
          end
          alloc = (act == A_FWD);
        end
        K_FLUSH, K_FENCE: begin
          // upstream to target; downstream flush aborts, fence drops
          if (!ipri && reach(ip, dp)) begin
            act = A_FWD;
            eg = dp;
            alloc = (d.kind == K_FLUSH);
          end else if (d.kind == K_FLUSH) begin
            act = A_MAREPLY;
          end else if (ipri) begin
            n.f_ce[ip] = 1'h1;
          end
        end
        default: begin
          // target selector or outside address decode
          if (ipri && (d.compat || !c.dec_en[ip])) t = dp;
          else t = d.dport;
          // legacy flag cleared between two secondaries
          if (!ipri && !is_primary[t] && t != ip) cpt = 1'h0;
          // only within partition, never primary to primary
          if (reach(ip, t) && !(ipri && is_primary[t])) begin
            act = A_FWD;
            eg = t;
            alloc = (d.kind == K_NONPOSTED);
          end else if (d.kind == K_NONPOSTED) begin
            act = A_MAREPLY;
          end
        end
      endcase
      // a forwarded nonposted, type 1 config or flush request waits while no entry or tag is free
      if (!(alloc && full)) begin
        n.seen = c.req_s2;
        n.eg_valid = 1'h1;
        n.eg_port = eg;
        n.eg_in = ip;
        n.eg_act = act;
        n.eg_kind = d.kind;
        n.eg_compat = cpt;
        n.eg_seq = sq;
        n.eg_rsp = rsp;
        n.eg_tag = tg;
        n.eg_unit = un;
        if (alloc) begin
          // record the original fields, reissue under a free tag
          n.tv[fi] = 1'h1;
          n.ttag[fi] = d.tag;
          n.tseq[fi] = d.seq;
          n.tunit[fi] = d.unit;
          n.tport[fi] = ip;
          n.eg_tag = TAG_W'(fi);
          n.eg_unit = port_unit[eg*UNIT_W +: UNIT_W];
        end
      end
    end
  end

  // enable low freezes the whole core state
  always_ff @(posedge clk or negedge rst_c) begin
    if (!rst_c) begin
      c <= '0;
      c.dec_en <= {NP{DECODE_EN_RST}};
      c.devnum <= {NP{DEVNUM_RST}};
    end else if (ce) begin
      c <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs from flip-flops, except tunnel_role which is decoded straight from the inputs

  assign dec_en = c.dec_en;
  // secondaries never report a tunnel role
  assign tunnel_role = tunnel_role_in & (is_primary | {NP{TUNNEL_ROLE_SEC}});
  assign eg_valid = c.eg_valid;
  assign eg_port = c.eg_port;
  assign eg_in_port = c.eg_in;
  assign eg_act = c.eg_act;
  assign eg_kind = c.eg_kind;
  assign eg_compat = c.eg_compat;
  assign eg_src_tag = c.eg_tag;
  assign eg_seq = c.eg_seq;
  assign eg_unit = c.eg_unit;
  assign eg_rsp = c.eg_rsp;
  assign chain_end_fault = c.f_ce;
  assign inbound_chain_end_fault = c.f_ice;
  assign unmatched_reply_fault = c.f_unm;
  assign sts_rx_mabort = c.s_rma;
  assign sec_rx_mabort = c.x_rma;
  assign sts_rx_tabort = c.s_rta;
  assign sec_rx_tabort = c.x_rta;
  assign sts_sig_tabort = c.s_sta;
  assign sec_sig_tabort = c.x_sta;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_c);

  sequence s_commit;
    ce && pend && !(alloc && full);
  endsequence
  sequence s_fence_ds;
    s_commit ##0 d.kind == K_FENCE && is_primary[d.port];
  endsequence

  AST_FENCE_DROP: assert property (s_fence_ds |=> eg_act == A_DROP && chain_end_fault[eg_in_port])
    else $error("downstream fence not dropped with fault");
  AST_FLUSH_DS: assert property (eg_valid && eg_kind == K_FLUSH && is_primary[eg_in_port]
    |-> eg_act == A_MAREPLY)
    else $error("downstream flush not aborted");
  AST_REACH: assert property (eg_valid && eg_act == A_FWD |-> reach(eg_in_port, eg_port))
    else $error("forward outside partition");
  AST_COMPAT_CLR: assert property (eg_valid && eg_act == A_FWD && !is_primary[eg_in_port]
    && !is_primary[eg_port] && eg_port != eg_in_port |-> !eg_compat)
    else $error("legacy flag kept between secondaries");
  AST_DECEN_RST: assert property ($rose(rst_c) |-> dec_en == '0 && c.devnum == '0)
    else $error("decode enable or device index not zero after reset");
  AST_STALL: assert property (ce && pend && alloc && full |=> !eg_valid && pend)
    else $error("request taken with table full");
  AST_TUNNEL: assert property ((tunnel_role & ~is_primary) == '0)
    else $error("secondary shows tunnel role");
  AST_RESP_DROP: assert property (eg_valid && eg_kind == K_RESP && eg_act == A_DROP
    |-> (chain_end_fault | inbound_chain_end_fault | unmatched_reply_fault) != '0)
    else $error("response dropped without fault");
  AST_ABORT_SAME: assert property (eg_valid && eg_kind == K_RESP && eg_act == A_FWD
    && eg_port == eg_in_port |-> sts_sig_tabort == '0)
    else $error("abort flags on reflected response");
endmodule
`default_nettype wire

/* rtl/swr_pkg.sv */
package swr_pkg;
  localparam int TAG_W  = 5;
  localparam int SEQ_W  = 4;
  localparam int UNIT_W = 5;
  localparam int BUS_W  = 8;
  localparam int DEV_W  = 5;
  localparam logic             DECODE_EN_RST   = 1'h0;
  localparam logic [DEV_W-1:0] DEVNUM_RST      = 5'h00;
  localparam logic             TUNNEL_ROLE_SEC = 1'h0;
  typedef enum logic [2:0] {
    K_POSTED = 3'b000, K_NONPOSTED = 3'b001, K_CFG0 = 3'b010, K_CFG1 = 3'b011,
    K_FLUSH = 3'b100, K_FENCE = 3'b101, K_RESP = 3'b110
  } kind_t;
  typedef enum logic [1:0] {
    A_FWD = 2'b00, A_DROP = 2'b01, A_MAREPLY = 2'b10, A_CFGHIT = 2'b11
  } act_t;
  typedef enum logic [1:0] {
    R_NORMAL = 2'b00, R_MABORT = 2'b01, R_TABORT = 2'b10
  } rsp_t;
endpackage
